// ===== core/eerd_pkg.sv
// Package for the serial EEPROM client: constants and carrier types.
package eerd_pkg;
    localparam int ADDR_W = 9;
    localparam logic [3:0] DEV_CODE = 4'h a;
    localparam logic [8:0] ADDR_RESET = 9'h 000;
    localparam logic [8:0] ADDR_ONE = 9'h 001;
    localparam logic [2:0] BIT_LAST = 3'h 7;
    localparam logic [2:0] BIT_FIRST = 3'h 0;
    // Control byte field positions.
    localparam int CB_CODE_HI = 7;
    localparam int CB_CODE_LO = 4;
    localparam int CB_CS_HIGH = 3;
    localparam int CB_CS_LOW = 2;
    localparam int CB_BLOCK = 1;
    localparam int CB_RW = 0;
    // Buffer shape.
    localparam int BUF_DEPTH = 2;
    localparam int BUF_W = 9;

    // Bus state machine, Gray-coded along the usual path.
    typedef enum logic [2:0] {
        EERD_IDLE = 3'b000,
        EERD_CTRL = 3'b001,
        EERD_CACK = 3'b011,
        EERD_ADDR = 3'b010,
        EERD_AACK = 3'b110,
        EERD_TX = 3'b111,
        EERD_MACK = 3'b101,
        EERD_WDAT = 3'b100
    } eerd_state_t;

    // Read request carried from the address logic to the array side.
    typedef struct packed {
        logic [8:0] addr;
    } eerd_req_t;
endpackage : eerd_pkg

// ===== core/eerd_buf.sv
// Two-entry valid/ready buffer for array read requests.
`timescale 1ns/1ps
module eerd_buf (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire eerd_pkg::eerd_req_t in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output eerd_pkg::eerd_req_t out_data
);
    eerd_pkg::eerd_req_t mem_r [eerd_pkg::BUF_DEPTH];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] count_r;

    // Honest full and empty come straight from the occupancy count.
    assign in_ready = (count_r != 2'h 2);
    assign out_valid = (count_r != 2'h 0);
    assign out_data = mem_r[rd_ptr_r];

    // Pointers and occupancy move on accepted handshakes only.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h 0;
        end else begin
            if (in_valid && in_ready) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (out_valid && out_ready) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            count_r <= count_r + 2'((in_valid && in_ready) ? 1 : 0)
                - 2'((out_valid && out_ready) ? 1 : 0);
        end
    end

    // Storage entries, one generate slot per entry.
    for (genvar i = 0; i < eerd_pkg::BUF_DEPTH; i++) begin : g_ent
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                mem_r[i] <= '0;
            end else if (in_valid && in_ready && (wr_ptr_r == 1'(i))) begin
                mem_r[i] <= in_data;
            end
        end
    end
endmodule : eerd_buf

// ===== core/eerd_client.sv
// Serial EEPROM client bus logic: addressing, polling and reads.
//
// Function
// R1: No acknowledge while write cycle busy.
// R2: Stop after write starts programming cycle.
// R3: Host polls with write control byte.
// R4: Host repeats Start and byte until acknowledged.
// R5: Acknowledge polling byte once cycle done.
// R6: Read control byte has direction one.
// R7: Current, random and sequential reads supported.
// R8: Address counter holds last location plus one.
// R9: Acknowledge read byte, send eight bits MSB-first.
// R10: Host no-ack plus Stop ends read.
// R11: Repeated Start keeps the loaded address.
// R12: Host resends control byte with read direction.
// R13: Pointer follows the byte just read.
// R14: Host acknowledge continues to next address.
// R15: Pointer increments after each byte operation.
// R16: Nine-bit pointer wraps to zero.
// R17: Match device code and chip-select pins.
// R18: Block-select bit is ninth address bit.
// R19: Byte after write control loads pointer.
// R20: Release data line after host no-ack.
// R21: Mismatched byte: stay released until Start.
// R22: Start mid-transfer aborts to control byte.
`timescale 1ns/1ps
module eerd_client (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Serial bus pins; data is open drain.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Chip-select straps.
    input wire logic chip_select_high,
    input wire logic chip_select_low,
    // Array read port.
    output logic rd_req_valid,
    input wire logic rd_req_ready,
    output logic [8:0] rd_addr,
    input wire logic rd_data_valid,
    input wire logic [7:0] rd_data,
    // Self-timed programming cycle.
    output logic prog_start,
    input wire logic prog_busy
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and condition detection.
    logic scl_m_r, scl_s_r, scl_d_r;
    logic sda_m_r, sda_s_r, sda_d_r;
    logic csh_m_r, csh_s_r, csl_m_r, csl_s_r;
    logic scl_rise, scl_fall, start_det, stop_det;

    // Every pin passes two flops before anything reads it.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
            csh_m_r <= 1'b0;
            csh_s_r <= 1'b0;
            csl_m_r <= 1'b0;
            csl_s_r <= 1'b0;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
            csh_m_r <= chip_select_high;
            csh_s_r <= csh_m_r;
            csl_m_r <= chip_select_low;
            csl_s_r <= csl_m_r;
        end
    end

    assign scl_rise = scl_s_r && !scl_d_r;
    assign scl_fall = !scl_s_r && scl_d_r;
    // Data edges while the clock stays high are Start and Stop.
    assign start_det = scl_s_r && scl_d_r && !sda_s_r && sda_d_r;
    assign stop_det = scl_s_r && scl_d_r && sda_s_r && !sda_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Bus state machine.
    eerd_pkg::eerd_state_t state_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [8:0] addr_r;
    logic rw_r;
    logic wrote_r;
    logic match;
    logic [7:0] rx_byte;
    logic [7:0] tx_r;
    logic tx_full_r;
    logic host_ack_r;
    eerd_pkg::eerd_req_t req_in;
    logic req_valid, req_ready;
    logic scl_seen_r;
    logic req_pend_r;
    eerd_pkg::eerd_req_t req_out;

    assign rx_byte = {shift_r[6:0], sda_s_r};
    // R17 device match
    assign match = (rx_byte[eerd_pkg::CB_CODE_HI:eerd_pkg::CB_CODE_LO] == eerd_pkg::DEV_CODE)
        && (rx_byte[eerd_pkg::CB_CS_HIGH] == csh_s_r)
        && (rx_byte[eerd_pkg::CB_CS_LOW] == csl_s_r);

    // Main sequencing on sampled clock edges; Start overrides everything.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r <= eerd_pkg::EERD_IDLE;
            bit_cnt_r <= eerd_pkg::BIT_FIRST;
            shift_r <= 8'h 00;
            rw_r <= 1'b0;
            host_ack_r <= 1'b0;
        end else if (start_det) begin
            // R22 start aborts
            state_r <= eerd_pkg::EERD_CTRL;
            bit_cnt_r <= eerd_pkg::BIT_FIRST;
        end else if (stop_det) begin
            state_r <= eerd_pkg::EERD_IDLE;
        end else begin
            case (state_r)
                eerd_pkg::EERD_CTRL, eerd_pkg::EERD_ADDR, eerd_pkg::EERD_WDAT: begin
                    if (scl_rise) begin
                        shift_r <= rx_byte;
                        bit_cnt_r <= bit_cnt_r + 3'h 1;
                        if (bit_cnt_r == eerd_pkg::BIT_LAST) begin
                            if (state_r == eerd_pkg::EERD_CTRL) begin
                                rw_r <= rx_byte[eerd_pkg::CB_RW];
                                // R1 busy no-ack
                                // R21 mismatch ignore
                                state_r <= (match && !prog_busy) ? eerd_pkg::EERD_CACK
                                    : eerd_pkg::EERD_IDLE;
                            end else begin
                                state_r <= eerd_pkg::EERD_AACK;
                            end
                        end
                    end
                end
                eerd_pkg::EERD_CACK, eerd_pkg::EERD_AACK: begin
                    // Leave the acknowledge slot on the falling edge.
                    if (scl_fall && scl_seen_r) begin
                        if (state_r == eerd_pkg::EERD_CACK && rw_r) begin
                            // R6 read direction
                            state_r <= eerd_pkg::EERD_TX;
                        end else if (state_r == eerd_pkg::EERD_CACK) begin
                            state_r <= eerd_pkg::EERD_ADDR;
                        end else begin
                            state_r <= eerd_pkg::EERD_WDAT;
                        end
                    end
                end
                eerd_pkg::EERD_TX: begin
                    if (scl_fall) begin
                        bit_cnt_r <= bit_cnt_r + 3'h 1;
                        if (bit_cnt_r == eerd_pkg::BIT_LAST) begin
                            state_r <= eerd_pkg::EERD_MACK;
                        end
                    end
                end
                eerd_pkg::EERD_MACK: begin
                    if (scl_rise) begin
                        host_ack_r <= !sda_s_r;
                    end
                    if (scl_fall && scl_seen_r) begin
                        // R14 ack continues
                        // R20 no-ack releases
                        state_r <= host_ack_r ? eerd_pkg::EERD_TX : eerd_pkg::EERD_IDLE;
                    end
                end
                default: begin
                    state_r <= eerd_pkg::EERD_IDLE;
                end
            endcase
        end
    end

    // Marks that a rising edge occurred inside an acknowledge slot, so the fall that
    // opened the slot is not mistaken for the one that closes it. The rise of the last
    // received bit must not count, since it comes before the opening fall.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            scl_seen_r <= 1'b0;
        end else if (scl_fall) begin
            scl_seen_r <= 1'b0;
        end else if (scl_rise && (state_r == eerd_pkg::EERD_CACK
            || state_r == eerd_pkg::EERD_AACK || state_r == eerd_pkg::EERD_MACK)) begin
            scl_seen_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address pointer and write tracking.
    logic ctrl_done, addr_done, byte_out_done, wdat_done;
    assign ctrl_done = !start_det && !stop_det && scl_rise
        && state_r == eerd_pkg::EERD_CTRL && bit_cnt_r == eerd_pkg::BIT_LAST
        && match && !prog_busy;
    assign addr_done = !start_det && !stop_det && scl_rise
        && state_r == eerd_pkg::EERD_ADDR && bit_cnt_r == eerd_pkg::BIT_LAST;
    assign wdat_done = !start_det && !stop_det && scl_rise
        && state_r == eerd_pkg::EERD_WDAT && bit_cnt_r == eerd_pkg::BIT_LAST;
    assign byte_out_done = !start_det && !stop_det && scl_fall
        && state_r == eerd_pkg::EERD_TX && bit_cnt_r == eerd_pkg::BIT_LAST;

    // The block-select bit and the address byte form the nine-bit pointer.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            addr_r <= eerd_pkg::ADDR_RESET;
        end else if (ctrl_done) begin
            // R18 block select
            addr_r[8] <= rx_byte[eerd_pkg::CB_BLOCK];
        end else if (addr_done) begin
            // R19 load pointer
            // R11 keep pointer
            addr_r[7:0] <= rx_byte;
        end else if (byte_out_done || wdat_done) begin
            // R15 increment
            // R16 wrap
            // R8 last plus one
            // R13 follows read
            addr_r <= addr_r + eerd_pkg::ADDR_ONE;
        end
    end

    // A write that received data starts the programming cycle at its Stop.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wrote_r <= 1'b0;
            prog_start <= 1'b0;
        end else begin
            // R2 stop starts cycle
            prog_start <= stop_det && wrote_r;
            if (stop_det || start_det) begin
                wrote_r <= 1'b0;
            end else if (wdat_done) begin
                wrote_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read fetch path through the two-entry buffer.
    // R7 read types
    assign req_valid = (state_r == eerd_pkg::EERD_CACK || state_r == eerd_pkg::EERD_MACK)
        && rw_r && !tx_full_r && !req_pend_r;
    assign req_in.addr = addr_r;

    // One fetch per byte slot; the flag clears when data arrives.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            req_pend_r <= 1'b0;
        end else if (start_det || stop_det) begin
            req_pend_r <= 1'b0;
        end else if (req_valid && req_ready) begin
            req_pend_r <= 1'b1;
        end else if (rd_data_valid) begin
            req_pend_r <= 1'b0;
        end
    end

    eerd_buf u_buf (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data(req_in),
        .out_valid(rd_req_valid),
        .out_ready(rd_req_ready),
        .out_data(req_out)
    );
    assign rd_addr = req_out.addr;

    // Holding register for the byte to shift out.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_r <= 8'h 00;
            tx_full_r <= 1'b0;
        end else if (rd_data_valid && req_pend_r) begin
            tx_r <= rd_data;
            tx_full_r <= 1'b1;
        end else if (byte_out_done || start_det || stop_det) begin
            tx_full_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data pin drive, updated on falling clock edges and released on Start and Stop.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sda_oe <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe <= 1'b0;
        end else if (scl_fall) begin
            case (state_r)
                // R5 ack when done
                // R9 ack read
                eerd_pkg::EERD_CACK, eerd_pkg::EERD_AACK: sda_oe <= !scl_seen_r
                    || (state_r == eerd_pkg::EERD_CACK && rw_r && !tx_r[7]);
                // R9 msb first
                eerd_pkg::EERD_TX: sda_oe <= (bit_cnt_r != eerd_pkg::BIT_LAST)
                    && !tx_r[3'h 6 - bit_cnt_r];
                // R10 stop transmitting
                eerd_pkg::EERD_MACK: sda_oe <= scl_seen_r && host_ack_r && !tx_r[7];
                default: sda_oe <= 1'b0;
            endcase
        end
    end
    assign sda_out = 1'b0;
endmodule : eerd_client

// ===== bench/eerd_client_monitor.sv
// Pin-level checker for the serial EEPROM client.
`timescale 1ns/1ps
module eerd_client_monitor (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Bus pins and handshakes.
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_oe,
    input wire logic rd_req_valid,
    input wire logic rd_req_ready,
    input wire logic [8:0] rd_addr,
    input wire logic prog_start,
    input wire logic prog_busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Bus conditions on the raw pins; the device only changes data while the clock is low.
    sequence start_seq;
        scl_in && $fell(sda_in);
    endsequence
    sequence stop_seq;
        scl_in && $rose(sda_in);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    // busy means silence.
    a_busy_no_ack: assert property (prog_busy |-> !sda_oe)
        else $error("data driven while programming");
    a_prog_pulse: assert property (prog_start |=> !prog_start)
        else $error("programming start longer than one cycle");
    a_prog_on_stop: assert property (prog_start |-> scl_in && sda_in)
        else $error("programming started outside a stop");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data changed while clock high");
    a_oe_slot_high: assert property ($rose(sda_oe) |=> sda_oe [*6])
        else $error("driven slot cut short");
    a_oe_slot_low: assert property ($fell(sda_oe) |=> !sda_oe [*6])
        else $error("released slot cut short");
    a_stop_release: assert property (stop_seq |=> !sda_oe [*8])
        else $error("data driven after stop");
    a_start_quiet: assert property (start_seq |=> !sda_oe [*8])
        else $error("data driven during control byte");
    a_req_hold: assert property (rd_req_valid && !rd_req_ready
        |=> rd_req_valid && $stable(rd_addr))
        else $error("fetch request dropped or changed");
endmodule : eerd_client_monitor

bind eerd_client eerd_client_monitor mon (.clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in),
    .sda_in(sda_in), .sda_oe(sda_oe), .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready),
    .rd_addr(rd_addr), .prog_start(prog_start), .prog_busy(prog_busy));

// ===== bench/eerd_host_model.sv
// Bus host model: drives the serial clock and pulls data low on demand.
`timescale 1ns/1ps
module eerd_host_model (
    // Clock.
    input wire logic clk_sys,
    // Bus wires.
    input wire logic sda,
    output logic scl,
    output logic host_low
);
    // Clock stands high and data is released between frames.
    initial begin
        scl = 1'b1;
        host_low = 1'b0;
    end
    // One bit of 8 cycles; five low cycles leave room for the device's late data change.
    task automatic bit_slot(input logic drive_low, output logic seen);
        scl = 1'b0;
        @(negedge clk_sys);
        host_low = drive_low;
        repeat (4) @(negedge clk_sys);
        scl = 1'b1;
        repeat (2) @(negedge clk_sys);
        seen = sda;
        @(negedge clk_sys);
    endtask : bit_slot
    task automatic start_cond;
        scl = 1'b0;
        @(negedge clk_sys);
        host_low = 1'b0;
        repeat (4) @(negedge clk_sys);
        scl = 1'b1;
        repeat (3) @(negedge clk_sys);
        host_low = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask : start_cond
    task automatic stop_cond;
        scl = 1'b0;
        @(negedge clk_sys);
        host_low = 1'b1;
        repeat (4) @(negedge clk_sys);
        scl = 1'b1;
        repeat (3) @(negedge clk_sys);
        host_low = 1'b0;
        repeat (6) @(negedge clk_sys);
    endtask : stop_cond
    // Eight bits out MSB first, then the acknowledge slot released.
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(~b[i], s);
        bit_slot(1'b0, s);
        ack = (s === 1'b0);
    endtask : put_byte
    task automatic get_byte(input logic ack_it, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(1'b0, d[i]);
        bit_slot(ack_it, s);
    endtask : get_byte
endmodule : eerd_host_model

// ===== bench/eeprom_i2c_read_and_ack_polling_tb.sv
// Self-checking bench for the serial EEPROM client.
`timescale 1ns/1ps
module eeprom_i2c_read_and_ack_polling_tb;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic scl;
    logic host_low;
    logic sda;
    logic sda_out;
    logic sda_oe;
    logic cs_high = 1'b0;
    logic cs_low = 1'b0;
    logic rd_req_valid;
    logic rd_req_ready = 1'b0;
    logic [8:0] rd_addr;
    logic rd_data_valid = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic prog_start;
    logic prog_busy;
    int busy_cnt = 0;
    int prog_cnt = 0;
    int pend = 0;
    logic [8:0] pend_a = 9'h000;
    logic [8:0] ptr = 9'h000;
    logic [31:0] seed = 32'hf3ce_1bab;
    logic [31:0] seed_a = 32'hf3ce_1bab;
    int error_cnt = 0;
    int checks = 0;

    always #25 clk_sys = ~clk_sys;
    // Open-drain wire with a pull-up.
    assign sda = (sda_oe ? sda_out : 1'b1) & ~host_low;
    assign prog_busy = (busy_cnt != 0);

    eerd_client dut (.clk_sys(clk_sys), .resetn(resetn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_high(cs_high), .chip_select_low(cs_low),
        .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready), .rd_addr(rd_addr),
        .rd_data_valid(rd_data_valid), .rd_data(rd_data), .prog_start(prog_start),
        .prog_busy(prog_busy));
    eerd_host_model host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .host_low(host_low));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction : lfsr_next
    function automatic logic [7:0] mem_val(input logic [8:0] a);
        return a[7:0] ^ {a[8], 7'h35};
    endfunction : mem_val
    function automatic logic [7:0] ctl(input logic a8, input logic rw);
        return {eerd_pkg::DEV_CODE, cs_high, cs_low, a8, rw};
    endfunction : ctl

    // Array with random ready stalls and a 3-cycle fetch; programming timer of 200 cycles.
    always @(negedge clk_sys) begin
        seed_a <= lfsr_next(seed_a);
        rd_req_ready <= seed_a[0] | ~rd_req_ready;
        rd_data_valid <= (pend == 1);
        rd_data <= (pend == 1) ? mem_val(pend_a) : ~rd_data;
        pend <= (pend != 0) ? pend - 1 : 0;
        // Accept against the ready level that the design samples at the next rising edge.
        if (rd_req_valid === 1'b1 && (seed_a[0] | ~rd_req_ready)) begin
            pend_a <= rd_addr;
            pend <= 3;
        end
        if (prog_start === 1'b1) begin
            busy_cnt <= 200;
            prog_cnt <= prog_cnt + 1;
        end else if (busy_cnt != 0) begin
            busy_cnt <= busy_cnt - 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic chk1(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic ack;
        host.put_byte(b, ack);
        chk1("ack", exp_ack, ack);
    endtask : send
    task automatic set_ptr(input logic [8:0] a);
        host.start_cond();
        send(ctl(a[8], 1'b0), 1'b1);
        send(a[7:0], 1'b1);
        ptr = a;
    endtask : set_ptr
    task automatic rd(input int n);
        logic [7:0] d;
        host.start_cond();
        send(ctl(ptr[8], 1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            host.get_byte(i < n - 1, d);
            chk8("data", mem_val(ptr), d);
            ptr = ptr + 9'h001;
        end
        host.stop_cond();
    endtask : rd

    // Watchdog: a hang counts as a mismatch.
    initial begin
        repeat (90000) @(posedge clk_sys);
        error_cnt++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        int n;
        logic ack;
        logic s;
        logic [7:0] d;
        logic [7:0] bad [3];
        bad = '{8'h10, 8'h08, 8'h04};
        seed = lfsr_next(seed);
        cs_high = seed[0];
        cs_low = seed[1];
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
        rd(1);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr_next(seed);
            set_ptr(seed[8:0]);
            rd(1 + i % 2);
        end
        rd(1);
        set_ptr(9'h1fe);
        rd(4);
        seed = lfsr_next(seed);
        set_ptr(seed[8:0]);
        send(seed[16:9], 1'b1);
        ptr = ptr + 9'h001;
        host.stop_cond();
        chk1("prog_start", 1'b1, prog_cnt == 1);
        n = 0;
        ack = 1'b0;
        while (ack !== 1'b1 && n < 10) begin
            host.start_cond();
            host.put_byte(ctl(ptr[8], 1'b0), ack);
            n++;
        end
        chk1("poll refused", 1'b1, n > 1);
        chk1("poll ack", 1'b1, ack);
        rd(1);
        for (int i = 0; i < 3; i++) begin
            host.start_cond();
            send(ctl(ptr[8], 1'b1) ^ bad[i], 1'b0);
            host.get_byte(1'b0, d);
            chk8("released", 8'hff, d);
            host.stop_cond();
        end
        host.start_cond();
        send(ctl(ptr[8], 1'b0), 1'b1);
        for (int i = 0; i < 4; i++) host.bit_slot(1'b1, s);
        rd(2);
        report_and_stop();
    end
endmodule : eeprom_i2c_read_and_ack_polling_tb
